// ---- logic/sub_swap_exec.v ----
// Execution unit for subtract-with-borrow and nibble-swap file instructions
// Behaviour
// - Result is file minus working minus inverted carry
// - Subtract result to working if dest 0, else file
// - Extended set, access bank, f<=95: indexed offset
// - Swap puts low nibble high, high nibble low
// - Swap result to working if dest 0, else file
// - Subtract sets zero flag on zero result
// - Subtract sets negative flag from result bit 7
`default_nettype none
`include "sub_swap_consts.vh"

module sub_swap_exec (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Instruction from the fetch stage, sampled in the decode phase
    input  wire [15:0] instr,
    input  wire        instr_valid,
    // Addressing context
    input  wire        ext_set_en,
    input  wire [3:0]  bank_select_register,
    input  wire [11:0] index_base,
    // Direct working register and carry loads from the core
    input  wire        w_load,
    input  wire [7:0]  w_load_data,
    input  wire        carry_load,
    input  wire        carry_load_data,
    // Data memory
    output reg  [11:0] mem_addr_q,
    input  wire [7:0]  mem_rd_data,
    output reg         mem_wr_en_q,
    output reg  [7:0]  mem_wr_data_q,
    // Architectural state
    output reg  [7:0]  w_q,
    output reg         carry_q,
    output reg         digit_carry_q,
    output reg         overflow_q,
    output reg         zero_q,
    output reg         negative_q,
    // Cycle phase and completion
    output reg  [1:0]  phase_q,
    output reg         done_q
);

    reg        active_q;
    reg        is_sub_q;
    reg        dest_file_q;
    reg  [7:0] operand_q;
    reg  [7:0] result_q;
    reg  [4:0] flags_q;
    reg  [11:0] addr_d;
    reg        is_sub_d;
    reg        is_swap_d;

    // Phase codes of the instruction cycle
    // Binary codes, counted through in order
    localparam [1:0] PH_DEC  = `PH_DECODE;
    localparam [1:0] PH_RD   = `PH_READ;
    localparam [1:0] PH_PROC = `PH_PROCESS;
    localparam [1:0] PH_WR   = `PH_WRITE;

    // Fields of the instruction word
    wire [5:0] opcode_f;
    wire       dest_f;
    wire       banked_f;
    wire [7:0] file_f;
    wire       low_file;
    wire       accept;
    wire       commit;

    wire [7:0] sub_diff;
    wire       sub_c;
    wire       sub_dig;
    wire       sub_ovf;
    wire       sub_z;
    wire       sub_n;
    wire [7:0] swapped;

    // Split the word once so decode and address agree on the fields
    assign opcode_f = instr[`OPC_HI:`OPC_LO];
    assign dest_f   = instr[`BIT_DEST];
    assign banked_f = instr[`BIT_BANKED];
    assign file_f   = instr[`F_HI:`F_LO];

    // Only the low part of the access bank can be index relative
    assign low_file = (file_f <= `IDX_LIMIT);
    // Unknown opcodes and empty slots are not taken
    assign accept   = instr_valid && (is_sub_d || is_swap_d);
    // Results land only at the write edge of a taken instruction
    assign commit   = (phase_q == PH_WR) && active_q;

    // Opcode match and effective address for the word on the fetch bus
    always @* begin
        is_sub_d  = (opcode_f == `OPC_SUB_BORROW);
        is_swap_d = (opcode_f == `OPC_NIBBLE_SWAP);
        if (banked_f) begin
            // Bank select register supplies the upper address bits
            addr_d = {bank_select_register, file_f};
        end else if (ext_set_en && low_file) begin
            // Wraps inside the data space rather than faulting
            addr_d = index_base + {4'h0, file_f};
        end else if (low_file) begin
            // Access bank, low half maps to bank zero
            addr_d = {`ACC_LOW_BANK, file_f};
        end else begin
            // Access bank, high half maps to the special function bank
            addr_d = {`ACC_SFR_BANK, file_f};
        end
    end

    // Arithmetic kept apart so its flags can be checked alone
    borrow_subtractor u_sub (
        .file_val         (operand_q),
        .w_val            (w_q),
        .carry_in         (carry_q),
        .diff             (sub_diff),
        .carry_out        (sub_c),
        .digit_carry_flag (sub_dig),
        .overflow_flag    (sub_ovf),
        .zero_out         (sub_z),
        .negative_out     (sub_n)
    );

    // Nibble exchange; no flag path, so a swap cannot disturb status
    assign swapped = {operand_q[`NIB_LOW_TOP:`NIB_LOW_BOT],
                      operand_q[`NIB_HIGH_TOP:`NIB_HIGH_BOT]};

    // Free-running phase counter: decode, read, process, write
    // Wraps from write back to decode, so instructions run back to back
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= PH_DEC;
        end else begin
            phase_q <= phase_q + `PH_STEP;
        end
    end

    // Instruction sequencing through the four phases
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_q      <= 1'b0;
            is_sub_q      <= 1'b0;
            dest_file_q   <= 1'b0;
            operand_q     <= `BYTE_RST;
            result_q      <= `BYTE_RST;
            flags_q       <= `FLAGS_RST;
            mem_addr_q    <= `ADDR_RST;
            mem_wr_en_q   <= 1'b0;
            mem_wr_data_q <= `BYTE_RST;
            done_q        <= 1'b0;
        end else begin
            mem_wr_en_q <= 1'b0;
            done_q      <= 1'b0;
            case (phase_q)
                PH_DEC: begin
                    // Unknown opcodes leave the unit idle for the cycle
                    active_q    <= accept;
                    is_sub_q    <= is_sub_d;
                    dest_file_q <= dest_f;
                    mem_addr_q  <= addr_d;
                end
                PH_RD: begin
                    // Memory must answer within this phase; no wait states
                    operand_q <= mem_rd_data;
                end
                PH_PROC: begin
                    // Flags staged for both; only a subtract commits them
                    result_q <= is_sub_q ? sub_diff : swapped;
                    flags_q  <= {sub_c, sub_dig, sub_ovf, sub_z, sub_n};
                end
                PH_WR: begin
                    // File write and done strobe each last one cycle
                    if (commit && dest_file_q) begin
                        mem_wr_en_q   <= 1'b1;
                        mem_wr_data_q <= result_q;
                    end
                    done_q   <= commit;
                    active_q <= 1'b0;
                end
                default: begin
                    active_q <= 1'b0;
                end
            endcase
        end
    end

    // Working register; the instruction write beats a core load
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            w_q <= `W_RST;
        end else begin
            if (commit && !dest_file_q) begin
                w_q <= result_q;
            end else if (w_load) begin
                // Core loads fill the cycles between instruction writes
                w_q <= w_load_data;
            end
        end
    end

    // Status flags; a subtract at the write edge beats a carry load
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            carry_q       <= 1'b0;
            digit_carry_q <= 1'b0;
            overflow_q    <= 1'b0;
            zero_q        <= 1'b0;
            negative_q    <= 1'b0;
        end else begin
            if (commit && is_sub_q) begin
                // Swap never reaches here, so it keeps every flag
                carry_q       <= flags_q[`FLAG_CARRY];
                digit_carry_q <= flags_q[`FLAG_DIGIT];
                overflow_q    <= flags_q[`FLAG_OVER];
                zero_q        <= flags_q[`FLAG_ZERO];
                negative_q    <= flags_q[`FLAG_NEG];
            end else if (carry_load) begin
                carry_q <= carry_load_data;
            end
        end
    end

endmodule // sub_swap_exec

`default_nettype wire

// ---- logic/sub_swap_consts.vh ----
// Constants for the subtract-with-borrow and nibble-swap execution unit
`ifndef SUB_SWAP_CONSTS_VH
`define SUB_SWAP_CONSTS_VH

// Opcode high six bits, instruction word bits 15:10
`define OPC_SUB_BORROW   6'h16
`define OPC_NIBBLE_SWAP  6'h0e
`define OPC_HI           15
`define OPC_LO           10
`define BIT_DEST         9
`define BIT_BANKED       8

// File address field and nibble positions
`define F_HI             7
`define F_LO             0
`define NIB_HIGH_TOP     7
`define NIB_HIGH_BOT     4
`define NIB_LOW_TOP      3
`define NIB_LOW_BOT      0

// Positions in the staged status word
`define FLAG_CARRY       4
`define FLAG_DIGIT       3
`define FLAG_OVER        2
`define FLAG_ZERO        1
`define FLAG_NEG         0

// Access bank split and indexed literal offset limit
`define IDX_LIMIT        8'h5f
`define ACC_LOW_BANK     4'h0
`define ACC_SFR_BANK     4'hf

// Phase codes within one instruction cycle
`define PH_DECODE        2'h0
`define PH_READ          2'h1
`define PH_PROCESS       2'h2
`define PH_WRITE         2'h3
`define PH_STEP          2'h1

// Reset values
`define W_RST            8'h00
`define ADDR_RST         12'h000
`define BYTE_RST         8'h00
`define FLAGS_RST        5'h00

`endif

// ---- logic/borrow_subtractor.v ----
// Subtract with borrow arithmetic and its status flags
`default_nettype none

module borrow_subtractor (
    // Operands
    input  wire [7:0] file_val,
    input  wire [7:0] w_val,
    input  wire       carry_in,
    // Result and flags
    output wire [7:0] diff,
    output wire       carry_out,
    output wire       digit_carry_flag,
    output wire       overflow_flag,
    output wire       zero_out,
    output wire       negative_out
);

    wire [8:0] sum_full;
    wire [4:0] sum_low;

    // Adding the complement keeps carry meaning no borrow
    assign sum_full = {1'b0, file_val} + {1'b0, ~w_val} + {8'h00, carry_in};
    assign sum_low  = {1'b0, file_val[3:0]} + {1'b0, ~w_val[3:0]} + {4'h0, carry_in};
    assign diff             = sum_full[7:0];
    assign carry_out        = sum_full[8];
    assign digit_carry_flag = sum_low[4];
    // Signs differ and result sign left the minuend
    assign overflow_flag    = (file_val[7] ^ w_val[7]) & (sum_full[7] ^ file_val[7]);
    assign zero_out         = (sum_full[7:0] == 8'h00);
    assign negative_out     = sum_full[7];

endmodule // borrow_subtractor

`default_nettype wire

// ---- sim/sub_swap_monitor.sv ----
// Assertion checker for the subtract-with-borrow and nibble-swap unit
`default_nettype none
module sub_swap_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Instruction side
    input wire logic [15:0] instr,
    input wire logic        instr_valid,
    input wire logic        ext_set_en,
    input wire logic [3:0]  bank_select_register,
    input wire logic [11:0] index_base,
    // Memory and state
    input wire logic [11:0] mem_addr_q,
    input wire logic [7:0]  mem_rd_data,
    input wire logic        mem_wr_en_q,
    input wire logic [7:0]  mem_wr_data_q,
    input wire logic [7:0]  w_q,
    input wire logic        carry_q,
    input wire logic        zero_q,
    input wire logic        negative_q,
    input wire logic [1:0]  phase_q,
    input wire logic        done_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Decode edge qualifiers
    wire dec = phase_q == 2'h0;
    wire sub_t = dec && instr_valid && instr[15:10] == 6'h16;
    wire swp_t = dec && instr_valid && instr[15:10] == 6'h0e;
    // Operand is read at phase 1, working value and carry used at phase 2
    property p_bank; dec && instr[8] |=>
        mem_addr_q == {$past(bank_select_register), $past(instr[7:0])}; endproperty
    a_bank: assert property (p_bank) else $error("bank addr");
    property p_idx; dec && !instr[8] && ext_set_en && instr[7:0] <= 8'h5f |=>
        mem_addr_q == $past(index_base) + $past(instr[7:0]); endproperty
    a_idx: assert property (p_idx) else $error("index addr");
    property p_subw; sub_t && !instr[9] |-> ##4
        w_q == $past(mem_rd_data, 3) - $past(w_q, 2) - !$past(carry_q, 2); endproperty
    a_subw: assert property (p_subw) else $error("sub to w");
    property p_zero; sub_t && !instr[9] |-> ##4 zero_q == (w_q == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_neg; sub_t && instr[9] |-> ##4 negative_q == mem_wr_data_q[7]; endproperty
    a_neg: assert property (p_neg) else $error("neg flag");
    property p_swap; swp_t && instr[9] |-> ##4 mem_wr_en_q &&
        mem_wr_data_q == {$past(mem_rd_data[3:0], 3), $past(mem_rd_data[7:4], 3)}; endproperty
    a_swap: assert property (p_swap) else $error("swap to f");
    property p_sflag; swp_t |-> ##4 carry_q == $past(carry_q, 3) &&
        zero_q == $past(zero_q, 3) && negative_q == $past(negative_q, 3); endproperty
    a_sflag: assert property (p_sflag) else $error("swap flags");
    property p_done; sub_t || swp_t |=> !done_q [*3] ##1 done_q; endproperty
    a_done: assert property (p_done) else $error("done timing");
    c_sub: cover property (sub_t && instr[9]);
    c_swap: cover property (swp_t && !instr[9]);
    c_idle: cover property (dec && !instr_valid);
endmodule // sub_swap_monitor
bind sub_swap_exec sub_swap_monitor u_mon (
    .clk                  (clk),
    .resetn               (resetn),
    .instr                (instr),
    .instr_valid          (instr_valid),
    .ext_set_en           (ext_set_en),
    .bank_select_register (bank_select_register),
    .index_base           (index_base),
    .mem_addr_q           (mem_addr_q),
    .mem_rd_data          (mem_rd_data),
    .mem_wr_en_q          (mem_wr_en_q),
    .mem_wr_data_q        (mem_wr_data_q),
    .w_q                  (w_q),
    .carry_q              (carry_q),
    .zero_q               (zero_q),
    .negative_q           (negative_q),
    .phase_q              (phase_q),
    .done_q               (done_q)
);
`default_nettype wire

// ---- sim/tb_sub_swap_exec.sv ----
// Self-checking bench for the subtract-with-borrow and nibble-swap unit
`default_nettype none
module tb_sub_swap_exec;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, resetn = 0, instr_valid = 0, ext_set_en = 0, w_load = 0, carry_load = 0;
    logic carry_load_data = 0, mem_wr_en_q, carry_q, digit_carry_q, overflow_q, zero_q;
    logic negative_q, done_q;
    logic [15:0] instr = 16'h0000;
    logic [11:0] index_base = 12'h000, mem_addr_q;
    logic [7:0] w_load_data = 8'h00, mem_rd_data = 8'h00, mem_wr_data_q, w_q;
    logic [3:0] bank_select_register = 4'h0;
    logic [1:0] phase_q;
    int failures = 0, checks_done = 0, cycles = 0;
    sub_swap_exec dut (
        .clk                  (clk),
        .resetn               (resetn),
        .instr                (instr),
        .instr_valid          (instr_valid),
        .ext_set_en           (ext_set_en),
        .bank_select_register (bank_select_register),
        .index_base           (index_base),
        .w_load               (w_load),
        .w_load_data          (w_load_data),
        .carry_load           (carry_load),
        .carry_load_data      (carry_load_data),
        .mem_addr_q           (mem_addr_q),
        .mem_rd_data          (mem_rd_data),
        .mem_wr_en_q          (mem_wr_en_q),
        .mem_wr_data_q        (mem_wr_data_q),
        .w_q                  (w_q),
        .carry_q              (carry_q),
        .digit_carry_q        (digit_carry_q),
        .overflow_q           (overflow_q),
        .zero_q               (zero_q),
        .negative_q           (negative_q),
        .phase_q              (phase_q),
        .done_q               (done_q)
    );
    // Clock and a ceiling on run length
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input logic [11:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single-bit results: strobes and status flags
    task automatic chk_bit(input logic got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One instruction cycle; W and carry preloaded at the decode edge
    task automatic run(input logic [5:0] op, input logic d, a, input logic [7:0] f, m, w,
                       input logic c, input logic [11:0] ea);
        logic sb, ok, ce, z, n, dig, ovf;
        logic [8:0] s;
        logic [4:0] lo;
        logic [7:0] r;
        while (phase_q !== 2'h0) @(negedge clk);
        sb = op == 6'h16;
        ok = sb || op == 6'h0e;
        // Borrow is the inverted carry; a flag set means no borrow
        s = {1'b0, m} - {1'b0, w} - {8'h00, !c};
        lo = {1'b0, m[3:0]} - {1'b0, w[3:0]} - {4'h0, !c};
        r = sb ? s[7:0] : {m[3:0], m[7:4]};
        ce = sb ? !s[8] : c;
        dig = sb ? !lo[4] : digit_carry_q;
        ovf = sb ? (m[7] != w[7]) && (r[7] != m[7]) : overflow_q;
        z = sb ? r == 8'h00 : zero_q;
        n = sb ? r[7] : negative_q;
        instr = {op, d, a, f};
        {instr_valid, w_load, w_load_data, carry_load, carry_load_data} = {2'h3, w, 1'b1, c};
        mem_rd_data = m;
        @(negedge clk);
        {w_load, carry_load, instr_valid} = 3'h0;
        chk(mem_addr_q, ea);
        @(negedge clk);
        // Memory no longer drives the operand after the read phase
        mem_rd_data = ~m;
        repeat (2) @(negedge clk);
        chk_bit(done_q, ok);
        chk_bit(mem_wr_en_q, ok & d);
        if (ok & d) chk(mem_wr_data_q, r);
        chk(w_q, ok & !d ? r : w);
        chk_bit(carry_q, ce);
        chk_bit(digit_carry_q, dig);
        chk_bit(overflow_q, ovf);
        chk_bit(zero_q, z);
        chk_bit(negative_q, n);
    endtask
    task automatic t_sub;
        bank_select_register = 4'h5;
        run(6'h16, 1, 1, 8'h20, 8'h19, 8'h0d, 1, 12'h520);
        run(6'h16, 0, 1, 8'hff, 8'h1b, 8'h1a, 0, 12'h5ff);
        run(6'h16, 1, 0, 8'h60, 8'h03, 8'h0e, 1, 12'hf60);
        run(6'h16, 0, 1, 8'h40, 8'h80, 8'h01, 1, 12'h540);
        $display("test sub done");
    endtask
    task automatic t_swap;
        ext_set_en = 1;
        index_base = 12'hfe0;
        run(6'h0e, 1, 0, 8'h5f, 8'h53, 8'h77, 0, 12'h03f);
        run(6'h0e, 0, 0, 8'h60, 8'ha6, 8'h01, 1, 12'hf60);
        ext_set_en = 0;
        run(6'h0e, 0, 0, 8'h10, 8'h0f, 8'h00, 0, 12'h010);
        $display("test swap done");
    endtask
    task automatic t_idle;
        repeat (4) @(negedge clk);
        run(6'h17, 1, 0, 8'h30, 8'h00, 8'h44, 1, 12'h030);
        // A known opcode with valid low is an empty slot
        while (phase_q !== 2'h0) @(negedge clk);
        instr = {6'h16, 1'b1, 1'b1, 8'h20};
        @(negedge clk);
        chk(mem_addr_q, 12'h520);
        repeat (3) @(negedge clk);
        chk_bit(done_q, 1'b0);
        chk_bit(mem_wr_en_q, 1'b0);
        chk(w_q, 8'h44);
        $display("test idle done");
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        resetn = 1;
        t_sub();
        t_swap();
        t_idle();
        final_report();
    end
endmodule // tb_sub_swap_exec
`default_nettype wire
